/* design/hlt_consts.svh */
`ifndef HLT_CONSTS_SVH
`define HLT_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define HLT_OFF_CTRL 3'h0
`define HLT_OFF_MODE 3'h1
`define HLT_OFF_PERIOD 3'h2
`define HLT_OFF_COUNT 3'h3
`define HLT_OFF_STATUS 3'h4

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define HLT_CTRL_ON_BIT 7
`define HLT_ST_FLAG_BIT 0
`define HLT_ST_RUN_BIT 1
`define HLT_ST_ARMED_BIT 2
`define HLT_CTRL_RST 8'h00
`define HLT_MODE_RST 5'h00
`define HLT_PERIOD_RST 8'hff
`define HLT_SYNC_STAGES 2

`endif

/* design/hlt_pkg.sv */
package hlt_pkg;

    // ------------------------------------------------------------
    // mode classes decoded from the mode field
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        HLT_FREE = 4'h0,
        HLT_GATE = 4'h1,
        HLT_EDGE_RST = 4'h2,
        HLT_LVL_RST = 4'h3,
        HLT_OS_SW = 4'h4,
        HLT_OS_EDGE = 4'h5,
        HLT_OS_EDGE_RST = 4'h6,
        HLT_OS_LVL_EDGE = 4'h7,
        HLT_MONO = 4'h8,
        HLT_OS_LVL = 4'h9,
        HLT_RESERVED = 4'ha
    } hlt_class_t;

    // ------------------------------------------------------------
    // control register layout
    // ------------------------------------------------------------
    typedef struct packed {
        logic on;
        logic [2:0] prescale_select;
        logic [3:0] postscale_select;
    } hlt_ctrl_t;

endpackage : hlt_pkg

/* design/hlt_prescale.sv */
module hlt_prescale (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic clear,
    input wire logic [2:0] prescale_select,
    output logic tick
);
    logic [6:0] div;
    logic [6:0] mask;

    // tick once every 2**prescale_select enabled clocks
    assign mask = 7'((8'h01 << prescale_select) - 8'h01);
    assign tick = ce && !clear && ((div & mask) == mask);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            div <= 7'h00;
        end else if (ce) begin
            div <= clear ? 7'h00 : 7'(div + 7'h01);
        end
    end
endmodule : hlt_prescale

/* design/hlt_sync.sv */
module hlt_sync #(
    parameter int WIDTH = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] stage1;

    // two-flop synchroniser; stage1 feeds only q
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stage1 <= '0;
            q <= '0;
        end else if (ce) begin
            stage1 <= d;
            q <= stage1;
        end
    end
endmodule : hlt_sync

/* design/hlt_timer.sv */
// The address map and strobed register access were left to the implementer.
`include "hlt_consts.svh"

// Overview of operation
// (RULE1) edge-started modes need a fresh edge after run control is set again
// (RULE2) one-shot match: next clock clears run control, count stops at zero
// (RULE3) monostable match: next clock stops count at zero, run stays set
// (RULE4) flag raised when postscaler reaches the selected ratio, 1 to 16
// (RULE5) software enables the interrupt outside before delivery
// (RULE6) run control and external signal pass two sync flops first
// (RULE7) software gate: count while running, wrap to zero after match
// (RULE8) gate modes: code 1 counts while high, code 2 while low
// (RULE9) edge limit modes reset count on either, rising or falling edge
// (RULE10) early reset restarts counting two clocks after the event
// (RULE11) level limit modes hold count reset at low or high level
// (RULE12) level limit modes ignore the external signal while stopped
// (RULE13) level reset and release take effect two clocks late
// (RULE14) software one-shot counts when set, match resets and clears run
// (RULE15) software sets run again for each further one-shot cycle
// (RULE16) software one-shot pause and resume keeps the count
// (RULE17) edge one-shot waits for its edge, match clears run control
// (RULE18) edge limit one-shot starts on first edge, later edges reset
// (RULE19) edge limit one-shot ignores edges until run is set
// (RULE20) level-reset one-shot holds at level, starts on leaving it
// (RULE21) level-reset one-shot needs a new edge after run is cleared
// (RULE22) clearing run resets prescaler, postscaler and mode state
// (RULE23) edge monostable starts on edge, stops at match keeping run
// (RULE24) level one-shot counts only while run set and away from level
// (RULE25) prescale divides by two to the power of the field, up to 128
// (RULE26) edges found by comparing successive synchronised samples
// (RULE27) reserved codes hold count at zero with no match events
module hlt_timer
    import hlt_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic ext_reset_signal,
    output logic [7:0] count_value,
    output logic [7:0] period_value,
    output logic period_match,
    output logic postscaled,
    output logic irq_flag
);
    // ------------------------------------------------------------
    // decode functions
    // ------------------------------------------------------------
    function automatic hlt_class_t decode_mode(input logic [4:0] m);
        hlt_class_t c;
        c = HLT_RESERVED;
        unique case (m[4:3])
            2'b00: begin
                if (m[2:0] == 3'h0) c = HLT_FREE;
                else if (m[2:0] <= 3'h2) c = HLT_GATE;
                else if (m[2:0] <= 3'h5) c = HLT_EDGE_RST;
                else c = HLT_LVL_RST;
            end
            2'b01: begin
                if (m[2:0] == 3'h0) c = HLT_OS_SW;
                else if (m[2:0] <= 3'h3) c = HLT_OS_EDGE;
                else if (m[2:0] <= 3'h5) c = HLT_OS_EDGE_RST;
                else c = HLT_OS_LVL_EDGE;
            end
            2'b10: begin
                if (m[2:0] >= 3'h1 && m[2:0] <= 3'h3) c = HLT_MONO;
                else if (m[2:0] >= 3'h6) c = HLT_OS_LVL;
                else c = HLT_RESERVED;
            end
            2'b11: c = HLT_RESERVED;
        endcase
        return c;
    endfunction : decode_mode

    // qualifying edge for the mode code
    function automatic logic edge_hit(input logic [4:0] m,
                                      input logic rise, input logic fall);
        logic h;
        h = 1'b0;
        unique case (m)
            5'h03, 5'h0b, 5'h13: h = rise || fall;
            5'h04, 5'h09, 5'h0c, 5'h0e, 5'h11: h = rise;
            5'h05, 5'h0a, 5'h0d, 5'h0f, 5'h12: h = fall;
            default: h = 1'b0;
        endcase
        return h;
    endfunction : edge_hit

    // ------------------------------------------------------------
    // registers and state
    // ------------------------------------------------------------
    hlt_ctrl_t ctrl;
    logic [4:0] mode;
    logic [3:0] post_cnt;
    logic armed;
    logic done;
    logic ers_d;
    logic [1:0] sync_q;
    logic on_s;
    logic ers_s;
    logic tick;

    // ------------------------------------------------------------
    // synchronisers and prescaler
    // ------------------------------------------------------------
    hlt_sync #(.WIDTH(`HLT_SYNC_STAGES)) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .d({ctrl.on, ext_reset_signal}),
        .q(sync_q)
    );
    assign on_s = sync_q[1]; // RULE6
    assign ers_s = sync_q[0]; // RULE6

    hlt_prescale u_pre (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .clear(!on_s),
        .prescale_select(ctrl.prescale_select),
        .tick(tick)
    ); // RULE25

    // ------------------------------------------------------------
    // mode decode and edge detection
    // ------------------------------------------------------------
    hlt_class_t cls;
    logic rise;
    logic fall;
    logic qual;
    logic at_rst_lvl;
    logic matched;
    logic one_shot;
    logic gate_ok;
    assign cls = decode_mode(mode);
    assign rise = ers_s && !ers_d; // RULE26
    assign fall = !ers_s && ers_d; // RULE26
    assign qual = on_s && edge_hit(mode, rise, fall); // RULE19
    assign at_rst_lvl = (ers_s == mode[0]); // RULE11
    assign matched = (count_value == period_value);
    assign one_shot = (cls == HLT_OS_SW) || (cls == HLT_OS_EDGE) ||
                      (cls == HLT_OS_EDGE_RST) || (cls == HLT_OS_LVL_EDGE) ||
                      (cls == HLT_OS_LVL);
    assign gate_ok = mode[0] ? ers_s : !ers_s; // RULE8

    // ------------------------------------------------------------
    // counter next state
    // ------------------------------------------------------------
    logic [7:0] next_count;
    logic next_armed;
    logic match_evt;
    logic run_en;
    logic hold_zero;
    logic early_rst;
    always_comb begin
        next_armed = armed;
        run_en = 1'b0;
        hold_zero = 1'b0;
        early_rst = 1'b0;
        unique case (cls)
            HLT_FREE: run_en = on_s; // RULE7
            HLT_GATE: run_en = on_s && gate_ok; // RULE8
            HLT_EDGE_RST: begin
                run_en = on_s;
                early_rst = qual; // RULE9 RULE10
            end
            HLT_LVL_RST: begin
                run_en = on_s && !at_rst_lvl; // RULE11 RULE13
                hold_zero = on_s && at_rst_lvl; // RULE12
            end
            HLT_OS_SW: run_en = on_s && !done; // RULE14 RULE16
            HLT_OS_EDGE, HLT_MONO: begin
                if (qual && !done) next_armed = 1'b1; // RULE17 RULE23
                run_en = on_s && armed && !done;
            end
            HLT_OS_EDGE_RST: begin
                if (qual && !done) next_armed = 1'b1; // RULE18
                early_rst = qual && armed; // RULE18
                run_en = on_s && armed && !done;
            end
            HLT_OS_LVL_EDGE: begin
                hold_zero = at_rst_lvl; // RULE20
                if (qual && !done) next_armed = 1'b1; // RULE20 RULE21
                run_en = on_s && armed && !done && !at_rst_lvl;
            end
            HLT_OS_LVL: begin
                hold_zero = at_rst_lvl; // RULE24
                run_en = on_s && !done && !at_rst_lvl; // RULE24
            end
            HLT_RESERVED: hold_zero = 1'b1; // RULE27
        endcase
        if (!on_s) next_armed = 1'b0; // RULE1 RULE22
        match_evt = run_en && tick && matched && !early_rst && !hold_zero;
        if (hold_zero || early_rst) next_count = 8'h00;
        else if (match_evt) next_count = 8'h00; // RULE2 RULE3 RULE7
        else if (run_en && tick) next_count = 8'(count_value + 8'h01);
        else next_count = count_value;
        if (match_evt && cls == HLT_MONO) next_armed = 1'b0; // RULE3
    end

    // one-shot match clears run control in the register
    logic hw_clr;
    logic sw_on_set;
    logic next_done;
    assign hw_clr = match_evt && one_shot; // RULE2 RULE14
    assign sw_on_set = wr && (addr == `HLT_OFF_CTRL) &&
                       wdata[`HLT_CTRL_ON_BIT];
    assign next_done = sw_on_set || !on_s ? 1'b0 :
                       (match_evt && (one_shot || cls == HLT_MONO)) ? 1'b1 :
                       done; // RULE15

    // ------------------------------------------------------------
    // postscaler
    // ------------------------------------------------------------
    logic post_hit;
    assign post_hit = match_evt && (post_cnt == ctrl.postscale_select);

    // ------------------------------------------------------------
    // register file writes
    // ------------------------------------------------------------
    logic flag_clr;
    assign flag_clr = wr && (addr == `HLT_OFF_STATUS) &&
                      wdata[`HLT_ST_FLAG_BIT];

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl <= `HLT_CTRL_RST;
            mode <= `HLT_MODE_RST;
            period_value <= `HLT_PERIOD_RST;
        end else if (ce) begin
            if (wr && addr == `HLT_OFF_CTRL) ctrl <= wdata;
            else if (hw_clr) ctrl.on <= 1'b0; // RULE2
            if (wr && addr == `HLT_OFF_MODE) mode <= wdata[4:0];
            if (wr && addr == `HLT_OFF_PERIOD) period_value <= wdata;
        end
    end

    // counter, mode state, edge history and postscaler
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count_value <= 8'h00;
            armed <= 1'b0;
            done <= 1'b0;
            ers_d <= 1'b0;
            post_cnt <= 4'h0;
            period_match <= 1'b0;
            postscaled <= 1'b0;
        end else if (ce) begin
            count_value <= next_count;
            armed <= next_armed;
            done <= next_done;
            ers_d <= ers_s; // RULE26
            period_match <= match_evt;
            postscaled <= post_hit; // RULE4
            if (!on_s || post_hit) post_cnt <= 4'h0; // RULE22
            else if (match_evt) post_cnt <= 4'(post_cnt + 4'h1);
        end
    end

    // sticky flag, hardware set wins over software clear
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_flag <= 1'b0;
        end else if (ce) begin
            if (post_hit) irq_flag <= 1'b1; // RULE4
            else if (flag_clr) irq_flag <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // register reads, data one cycle after the strobe
    // ------------------------------------------------------------
    logic [7:0] rd_mux;
    assign rd_mux = (addr == `HLT_OFF_CTRL) ? ctrl :
                    (addr == `HLT_OFF_MODE) ? {3'h0, mode} :
                    (addr == `HLT_OFF_PERIOD) ? period_value :
                    (addr == `HLT_OFF_COUNT) ? count_value :
                    (addr == `HLT_OFF_STATUS) ?
                        {5'h00, armed, on_s, irq_flag} : 8'h00;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata <= 8'h00;
        end else if (ce) begin
            rdata <= rd ? rd_mux : 8'h00;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_os_clear;
        @(posedge clk) disable iff (!rst_n)
        (match_evt && one_shot && ce && !wr) |=>
            (count_value == 8'h00) && !ctrl.on;
    endproperty
    a_os_clear: assert property (p_os_clear) // RULE2
        else $error("one-shot match did not stop and clear run");

    property p_mono_keep;
        @(posedge clk) disable iff (!rst_n)
        (match_evt && cls == HLT_MONO && ce && !wr) |=>
            (count_value == 8'h00) && ctrl.on && !armed;
    endproperty
    a_mono_keep: assert property (p_mono_keep) // RULE3
        else $error("monostable match changed run or count");

    property p_post;
        @(posedge clk) disable iff (!rst_n)
        (post_hit && ce) |=> postscaled && irq_flag && (post_cnt == 4'h0);
    endproperty
    a_post: assert property (p_post) // RULE4
        else $error("postscaler hit not flagged");

    property p_sync;
        @(posedge clk) disable iff (!rst_n)
        $rose(ctrl.on) |-> !on_s ##1 !on_s;
    endproperty
    a_sync: assert property (p_sync) // RULE6
        else $error("run control passed sync too fast");

    property p_sw_gate;
        @(posedge clk) disable iff (!rst_n)
        (cls == HLT_FREE && run_en && tick && !matched) |=>
            count_value == 8'($past(count_value) + 8'h01);
    endproperty
    a_sw_gate: assert property (p_sw_gate) // RULE7
        else $error("software gate count did not increment");

    property p_gate;
        @(posedge clk) disable iff (!rst_n)
        (cls == HLT_GATE && ce && (mode[0] ? !ers_s : ers_s)) |=>
            $stable(count_value);
    endproperty
    a_gate: assert property (p_gate) // RULE8
        else $error("gated count moved");

    property p_edge_rst;
        @(posedge clk) disable iff (!rst_n)
        (cls == HLT_EDGE_RST && qual && ce) |=> count_value == 8'h00;
    endproperty
    a_edge_rst: assert property (p_edge_rst) // RULE9
        else $error("edge did not reset count");

    property p_lvl_ignore;
        @(posedge clk) disable iff (!rst_n)
        (cls == HLT_LVL_RST && !on_s && ce) |=> $stable(count_value);
    endproperty
    a_lvl_ignore: assert property (p_lvl_ignore) // RULE12
        else $error("stopped level mode reacted to signal");

    property p_reserved;
        @(posedge clk) disable iff (!rst_n)
        (cls == HLT_RESERVED && ce) |=>
            (count_value == 8'h00) && !period_match;
    endproperty
    a_reserved: assert property (p_reserved) // RULE27
        else $error("reserved mode counted");

    c_os_match: cover property (@(posedge clk) hw_clr);
    c_mono_match: cover property (@(posedge clk)
        match_evt && cls == HLT_MONO);
    c_edge_rst: cover property (@(posedge clk) early_rst && |count_value);
    c_post: cover property (@(posedge clk) post_hit && post_cnt != 4'h0);
endmodule : hlt_timer

/* tb/hardware_limit_timer_modes_tb.sv */
`include "hlt_consts.svh"

module hardware_limit_timer_modes_tb
    import hlt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk, rst_n, ce, wr, rd, ext_reset_signal;
    logic [2:0] addr;
    logic [7:0] wdata, rdata, count_value, period_value, rv;
    logic period_match, postscaled, irq_flag, pwm_out, cpu_irq;
    int error_cnt, tests_run, g, n;

    hlt_timer dut_u (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .addr(addr),
        .wdata(wdata),
        .wr(wr),
        .rd(rd),
        .rdata(rdata),
        .ext_reset_signal(ext_reset_signal),
        .count_value(count_value),
        .period_value(period_value),
        .period_match(period_match),
        .postscaled(postscaled),
        .irq_flag(irq_flag)
    );
    hlt_far_side far_u (
        .clk(clk),
        .count_value(count_value),
        .irq_flag(irq_flag),
        .ext_reset_signal(ext_reset_signal),
        .pwm_out(pwm_out),
        .cpu_irq(cpu_irq)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
            error_cnt++;
        end
    endtask : chk

    task automatic ok(input logic c);
        chk({15'h0, c}, 16'h0001);
    endtask : ok

    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [2:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 rv = rdata;
    endtask : rd_reg

    task automatic setup(input logic [4:0] m, input logic [7:0] p,
                         input logic [7:0] c);
        wr_reg(`HLT_OFF_CTRL, 8'h00);
        wr_reg(`HLT_OFF_MODE, {3'h0, m});
        wr_reg(`HLT_OFF_PERIOD, p);
        wr_reg(`HLT_OFF_CTRL, c);
    endtask : setup

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : tick

    task automatic wait_match;
        n = 0;
        while (period_match !== 1'b1 && n < 600) begin
            tick(1);
            n++;
        end
        ok(n < 600);
    endtask : wait_match

    // cycles between two successive pulses of one output
    task automatic gap(input logic ps);
        g = 0;
        do begin tick(1); g++; end
        while ((ps ? postscaled : period_match) !== 1'b1 && g < 600);
        g = 0;
        do begin tick(1); g++; end
        while ((ps ? postscaled : period_match) !== 1'b1 && g < 600);
    endtask : gap

    task automatic hold_zero(input int k);
        repeat (k) begin
            tick(1);
            chk(count_value, 8'h00);
            ok(period_match !== 1'b1);
        end
    endtask : hold_zero

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_regs;
        rd_reg(`HLT_OFF_CTRL);
        chk(rv, `HLT_CTRL_RST);
        rd_reg(`HLT_OFF_PERIOD);
        chk(rv, `HLT_PERIOD_RST);
        rd_reg(3'h6);
        chk(rv, 8'h00);
        chk(period_value, 8'hff);
    endtask : t_regs

    task automatic t_free_scale;
        setup(5'h00, 8'h03, 8'h80);
        gap(1'b0);
        chk(g, 4);
        chk(count_value, 8'h00);
        ok(pwm_out);
        setup(5'h00, 8'h01, 8'h82);
        gap(1'b1);
        chk(g, 6);
        setup(5'h00, 8'h01, 8'h8f);
        gap(1'b1);
        chk(g, 32);
        ok(cpu_irq === 1'b0);
        far_u.set_irq_en(1'b1);
        tick(1);
        ok(cpu_irq);
        wr_reg(`HLT_OFF_CTRL, 8'h00);
        wr_reg(`HLT_OFF_STATUS, 8'h01);
        tick(1);
        ok(irq_flag === 1'b0);
        setup(5'h00, 8'h01, 8'ha0);
        gap(1'b0);
        chk(g, 8);
        setup(5'h00, 8'h01, 8'hf0);
        gap(1'b0);
        chk(g, 256);
    endtask : t_free_scale

    task automatic t_gate;
        far_u.set_ers(1'b0);
        setup(5'h01, 8'hff, 8'h80);
        tick(10);
        rv = count_value;
        tick(10);
        chk(count_value, rv);
        far_u.set_ers(1'b1);
        tick(10);
        ok(count_value !== rv);
        // clock enable low freezes the count and ignores strobes
        @(posedge clk);
        ce <= 1'b0;
        tick(1);
        rv = count_value;
        wr_reg(`HLT_OFF_PERIOD, 8'h10);
        tick(4);
        chk(count_value, rv);
        chk(period_value, 8'hff);
        @(posedge clk);
        ce <= 1'b1;
        tick(3);
        ok(count_value !== rv);
    endtask : t_gate

    task automatic t_edge_rst;
        setup(5'h04, 8'hff, 8'h80);
        far_u.set_ers(1'b0);
        tick(20);
        ok(count_value > 8'h0a);
        far_u.set_ers(1'b1);
        n = 0;
        while (count_value !== 8'h00 && n < 8) begin
            tick(1);
            n++;
        end
        ok(n < 8);
        tick(5);
        ok(count_value < 8'h06 && count_value > 8'h00);
        far_u.set_ers(1'b0);
        tick(6);
        ok(count_value > 8'h06);
    endtask : t_edge_rst

    task automatic t_level;
        setup(5'h07, 8'hff, 8'h80);
        tick(10);
        far_u.set_ers(1'b1);
        tick(4);
        hold_zero(10);
        far_u.set_ers(1'b0);
        tick(5);
        ok(count_value !== 8'h00);
        wr_reg(`HLT_OFF_CTRL, 8'h00);
        tick(3);
        rv = count_value;
        far_u.set_ers(1'b1);
        tick(6);
        chk(count_value, rv);
        far_u.set_ers(1'b0);
    endtask : t_level

    task automatic t_rsvd;
        setup(5'h10, 8'h03, 8'h80);
        tick(4);
        hold_zero(20);
    endtask : t_rsvd

    task automatic t_one_shot;
        setup(5'h08, 8'h04, 8'h80);
        wait_match;
        tick(3);
        rd_reg(`HLT_OFF_CTRL);
        ok(rv[7] === 1'b0);
        hold_zero(8);
        setup(5'h08, 8'h28, 8'h80);
        tick(15);
        wr_reg(`HLT_OFF_CTRL, 8'h00);
        tick(3);
        rv = count_value;
        tick(10);
        chk(count_value, rv);
        wr_reg(`HLT_OFF_CTRL, 8'h80);
        tick(6);
        ok(count_value > rv);
        wait_match;
    endtask : t_one_shot

    task automatic t_edge_os;
        setup(5'h09, 8'h04, 8'h80);
        hold_zero(10);
        far_u.set_ers(1'b1);
        wait_match;
        tick(3);
        rd_reg(`HLT_OFF_CTRL);
        ok(rv[7] === 1'b0);
        wr_reg(`HLT_OFF_CTRL, 8'h80);
        hold_zero(10);
    endtask : t_edge_os

    task automatic t_mono;
        far_u.set_ers(1'b0);
        setup(5'h11, 8'h04, 8'h80);
        tick(4);
        far_u.set_ers(1'b1);
        wait_match;
        hold_zero(6);
        rd_reg(`HLT_OFF_CTRL);
        ok(rv[7]);
    endtask : t_mono

    // edge limit one-shot, then level one-shot with low reset level
    task automatic t_os_hw;
        setup(5'h0c, 8'h30, 8'h80);
        hold_zero(6);
        far_u.set_ers(1'b0);
        far_u.set_ers(1'b1);
        tick(10);
        ok(count_value > 8'h04);
        far_u.set_ers(1'b0);
        far_u.set_ers(1'b1);
        tick(3);
        chk(count_value, 8'h00);
        tick(2);
        chk(count_value, 8'h02);
        wait_match;
        far_u.set_ers(1'b0);
        setup(5'h16, 8'h05, 8'h80);
        hold_zero(6);
        far_u.set_ers(1'b1);
        wait_match;
        tick(3);
        rd_reg(`HLT_OFF_CTRL);
        ok(rv[7] === 1'b0);
    endtask : t_os_hw

    // ------------------------------------------------------------
    // run control
    // ------------------------------------------------------------
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : give_verdict

    // free running clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // hang guard
    initial begin
        #100000;
        error_cnt++;
        give_verdict;
    end

    // main sequence
    initial begin
        error_cnt = 0;
        tests_run = 0;
        rst_n = 1'b0;
        ce = 1'b1;
        addr = 3'h0;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        t_regs;
        t_free_scale;
        t_gate;
        t_edge_rst;
        t_level;
        t_rsvd;
        t_one_shot;
        t_edge_os;
        t_mono;
        t_os_hw;
        give_verdict;
    end
endmodule : hardware_limit_timer_modes_tb

/* tb/hlt_far_side.sv */
// ----------------------------------------------------------------
// far side: reset source, irq gate and pwm compare
// ----------------------------------------------------------------
module hlt_far_side
    import hlt_pkg::*;
#(
    parameter logic [7:0] CMP = 8'h02
) (
    input wire logic clk,
    input wire logic [7:0] count_value,
    input wire logic irq_flag,
    output logic ext_reset_signal,
    output logic pwm_out,
    output logic cpu_irq
);
    timeunit 1ns;
    timeprecision 1ps;

    logic timer_irq_enable;

    // quiet defaults until the bench asks for activity
    initial begin
        ext_reset_signal = 1'b0;
        timer_irq_enable = 1'b0;
    end

    // drive the external level just after an edge
    task automatic set_ers(input logic v);
        @(posedge clk);
        ext_reset_signal <= v;
    endtask : set_ers

    // software side enables delivery of the flag
    task automatic set_irq_en(input logic v);
        @(posedge clk);
        timer_irq_enable <= v;
    endtask : set_irq_en

    // irq gated outside the timer, pwm high below compare
    assign cpu_irq = irq_flag & timer_irq_enable;
    assign pwm_out = count_value < CMP;
endmodule : hlt_far_side
